// file: verilog/rfc_pkg.sv
// Shared constants, field layouts and carrier types of the remote command frame codec.
// =====================================================================
// Functional notes
// - Frame opens with one start delimiter byte.
// - Sixteen-bit length counts bytes before checksum.
// - Offset three type; 0x17 is remote request.
// - Correlation ID zero means no response frame.
// - Remote request answered by 0x97, same ID.
// - Option 0x01 suppresses link acknowledgements.
// - Option 0x02 applies now, else pending.
// - Option 0x10 secure, needs existing session.
// - Offset sixteen holds two command characters.
// - Empty parameter span queries current setting.
// - Checksum is 0xFF minus body sum.
// - Zero transmit options select default options.
// - Explicit request answered by 0x8B status.
// - Loopback cluster returns receive frame per format.
package rfc_pkg;
  // =====================================================================
  // Frame bytes and types.
  localparam logic [7:0] DELIM = 8'h7E;
  localparam logic [7:0] TYPE_REMOTE = 8'h17;
  localparam logic [7:0] TYPE_REMOTE_RSP = 8'h97;
  localparam logic [7:0] TYPE_EXPLICIT = 8'h11;
  localparam logic [7:0] TYPE_XSTAT = 8'h8B;
  localparam logic [7:0] TYPE_RX = 8'h90;
  localparam logic [7:0] TYPE_RX_EXPL = 8'h91;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
  localparam logic [7:0] RX_OPT_ACKED = 8'h01;
  localparam logic [15:0] CLUSTER_LOOP = 16'h0012;
  localparam logic [15:0] CMD_APPLY = 16'h4143;
  // Option bit positions.
  localparam int OPT_NO_ACK = 0;
  localparam int OPT_APPLY = 1;
  localparam int OPT_SECURE = 4;
  // =====================================================================
  // Body positions, counted from the type byte.
  localparam logic [15:0] FRAME_HDR = 16'h0003;
  localparam logic [15:0] POS_TYPE = 16'h0000;
  localparam logic [15:0] POS_FID = 16'h0001;
  localparam logic [15:0] POS_DST64 = 16'h0002;
  localparam logic [15:0] POS_DST16 = 16'h000A;
  localparam logic [15:0] POS_ROPT = 16'h000C;
  localparam logic [15:0] POS_RCMD = 16'h000D;
  localparam logic [15:0] POS_RPARAM = 16'h000F;
  localparam logic [15:0] POS_SEP = 16'h000C;
  localparam logic [15:0] POS_DEP = 16'h000D;
  localparam logic [15:0] POS_CLU = 16'h000E;
  localparam logic [15:0] POS_PRO = 16'h0010;
  localparam logic [15:0] POS_XOPT = 16'h0013;
  localparam logic [15:0] POS_XDATA = 16'h0014;
  // Response body lengths without variable data.
  localparam logic [15:0] RSP_REMOTE_LEN = 16'h000F;
  localparam logic [15:0] RSP_XSTAT_LEN = 16'h0007;
  localparam logic [15:0] RSP_RX_LEN = 16'h000C;
  localparam logic [15:0] RSP_RXE_LEN = 16'h0012;
  localparam logic [2:0] PARAM_BYTES = 3'h4;
  // Status codes.
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ERR = 8'h01;
  localparam logic [7:0] ST_BAD_PARAM = 8'h03;
  localparam logic [7:0] DELIV_FAIL = 8'h21;
  // =====================================================================
  // Register map, byte addresses, and control fields.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_FMT = 8;
  localparam int CTRL_SECURE = 9;
  // =====================================================================
  // Carrier types.
  typedef enum {K_REMOTE, K_STATUS, K_LOOP} rfc_kind_t;
  typedef struct packed {
    logic [15:0] command;
    logic [31:0] param;
    logic [2:0] plen;
    logic apply;
    logic no_ack;
    logic secure;
    logic query;
  } rfc_cmd_t;
  typedef struct packed {
    logic [7:0] opts;
    logic [15:0] cluster;
    logic loopback;
  } rfc_xmit_t;
endpackage

// file: verilog/rfc_mem.sv
// Byte store for loopback payload, with registered read data.
`timescale 1ns/1ps
module rfc_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // Storage array; contents need no reset since reads follow writes.
  logic [7:0] mem [DEPTH];

  // Write and registered read share one clock-enabled process.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// file: verilog/rfc_codec.sv
// Frame parser and response builder of the remote command frame codec.
`timescale 1ns/1ps
module rfc_codec
  import rfc_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output rfc_cmd_t cmd,
  output logic cmd_valid,
  output logic apply_strobe,
  input wire logic node_done,
  input wire logic node_err,
  input wire logic [31:0] node_value,
  input wire logic [2:0] node_len,
  output rfc_xmit_t xmit,
  output logic xmit_valid,
  input wire logic deliver_fail
);
  // =====================================================================
  // Helpers.
  // Byte k of a 64-bit field, most significant byte first.
  function automatic logic [7:0] pick64(input logic [63:0] v, input logic [15:0] k);
    logic [63:0] s;
    s = v << {k[2:0], 3'b000};
    return s[63:56];
  endfunction
  // Byte k of a 16-bit field, most significant byte first.
  function automatic logic [7:0] pick16(input logic [15:0] v, input logic [15:0] k);
    return k[0] ? v[7:0] : v[15:8];
  endfunction

  typedef enum {RX_HUNT, RX_LEN_HI, RX_LEN_LO, RX_BODY, RX_CSUM} rfc_rx_t;
  typedef enum {TX_IDLE, TX_FETCH, TX_PUT, TX_WAIT} rfc_tx_t;

  // =====================================================================
  // Receive state and captured fields.
  rfc_rx_t rx_st; // Parser state.
  logic [15:0] len; // Body length from the frame.
  logic [15:0] pos; // Body position of the next byte.
  logic [7:0] sum; // Running body sum.
  logic [7:0] ftype; // Frame type.
  logic [7:0] fid; // Correlation identifier.
  logic [63:0] dst64; // Destination long address.
  logic [15:0] dst16; // Destination network address.
  logic [7:0] ropt; // Remote command options.
  logic [15:0] rcmd; // Two command characters.
  logic [31:0] param; // Parameter bytes, right aligned.
  logic [7:0] sep; // Source endpoint.
  logic [7:0] dep; // Destination endpoint.
  logic [15:0] cluster; // Cluster of an explicit request.
  logic [15:0] profile; // Profile of an explicit request.
  logic [7:0] xopt; // Raw transmit options.
  logic [31:0] ctrl; // Control register.
  logic apply_pending; // A written value awaits apply.
  logic [7:0] good_cnt; // Accepted frames.
  logic [7:0] bad_cnt; // Checksum failures.

  wire rx_take = ce && rx_valid && rx_ready;
  wire in_body = rx_take && (rx_st == RX_BODY);
  wire frame_end = rx_take && (rx_st == RX_CSUM);
  wire [7:0] sum_next = sum + rx_byte;
  wire csum_good = (sum_next == CSUM_BASE);
  wire [15:0] plen_full = len - POS_RPARAM;
  wire is_remote = (ftype == TYPE_REMOTE) && (len >= POS_RPARAM);
  wire is_expl = (ftype == TYPE_EXPLICIT) && (len >= POS_XDATA)
    && ((len - POS_XDATA) <= 16'(DEPTH));
  wire good_end = frame_end && csum_good;
  wire rem_end = good_end && is_remote;
  wire expl_end = good_end && is_expl;
  wire secure_bad = ropt[OPT_SECURE] && !ctrl[CTRL_SECURE];
  wire param_bad = plen_full > 16'(PARAM_BYTES);
  wire rem_issue = rem_end && !secure_bad && !param_bad;
  wire is_query = (plen_full == 16'h0000);
  wire [7:0] eff_opts = (xopt == 8'h00) ? ctrl[7:0] : xopt;

  // Parser sequencing: hunt, length, body, checksum.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_st <= RX_HUNT;
      len <= 16'h0000;
      pos <= 16'h0000;
      sum <= 8'h00;
    end
    else if (rx_take)
    begin
      case (rx_st)
        RX_HUNT:
          if (rx_byte == DELIM)
            rx_st <= RX_LEN_HI;
        RX_LEN_HI:
        begin
          len[15:8] <= rx_byte;
          rx_st <= RX_LEN_LO;
        end
        RX_LEN_LO:
        begin
          // An empty body cannot carry a type, so the frame is dropped.
          len[7:0] <= rx_byte;
          pos <= 16'h0000;
          sum <= 8'h00;
          rx_st <= ({len[15:8], rx_byte} == 16'h0000) ? RX_HUNT : RX_BODY;
        end
        RX_BODY:
        begin
          sum <= sum_next;
          pos <= pos + 16'h0001;
          if (pos == len - 16'h0001)
            rx_st <= RX_CSUM;
        end
        RX_CSUM:
          rx_st <= RX_HUNT;
        default:
          rx_st <= RX_HUNT;
      endcase
    end
  end

  // Field capture by body position; all multi-byte fields arrive MSB first.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ftype <= 8'h00;
      fid <= 8'h00;
      dst64 <= 64'h0;
      dst16 <= 16'h0000;
      ropt <= 8'h00;
      rcmd <= 16'h0000;
      param <= 32'h0;
    end
    else if (in_body)
    begin
      if (pos == POS_TYPE)
        ftype <= rx_byte;
      if (pos == POS_FID)
        fid <= rx_byte;
      if (pos >= POS_DST64 && pos < POS_DST16)
        dst64 <= {dst64[55:0], rx_byte};
      if (pos >= POS_DST16 && pos < POS_ROPT)
        dst16 <= {dst16[7:0], rx_byte};
      if (pos == POS_ROPT)
        ropt <= rx_byte;
      if (pos >= POS_RCMD && pos < POS_RPARAM)
        rcmd <= {rcmd[7:0], rx_byte};
      if (pos == POS_RCMD)
        param <= 32'h0;
      if (pos >= POS_RPARAM)
        param <= {param[23:0], rx_byte};
    end
  end

  // Explicit request fields; payload goes to the byte store.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sep <= 8'h00;
      dep <= 8'h00;
      cluster <= 16'h0000;
      profile <= 16'h0000;
      xopt <= 8'h00;
    end
    else if (in_body)
    begin
      if (pos == POS_SEP)
        sep <= rx_byte;
      if (pos == POS_DEP)
        dep <= rx_byte;
      if (pos >= POS_CLU && pos < POS_PRO)
        cluster <= {cluster[7:0], rx_byte};
      if (pos >= POS_PRO && pos < POS_PRO + 16'h0002)
        profile <= {profile[7:0], rx_byte};
      if (pos == POS_XOPT)
        xopt <= rx_byte;
    end
  end

  // =====================================================================
  // Register port and counters.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl <= CTRL_RST;
      reg_rdata <= 32'h0;
      good_cnt <= 8'h00;
      bad_cnt <= 8'h00;
    end
    else if (ce)
    begin
      if (reg_wr && reg_addr == REG_CTRL)
        ctrl <= {22'h0, reg_wdata[9:0]};
      // Unmapped addresses read as zero.
      reg_rdata <= !reg_rd ? 32'h0 : (reg_addr == REG_CTRL) ? ctrl
        : (reg_addr == REG_STAT) ? {7'h0, !rx_ready, bad_cnt, good_cnt, 7'h0, apply_pending}
        : 32'h0;
      if (good_end)
        good_cnt <= good_cnt + 8'h01;
      if (frame_end && !csum_good)
        bad_cnt <= bad_cnt + 8'h01;
    end
  end

  // =====================================================================
  // Requests toward the node and the radio, and apply tracking.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmd <= '0;
      cmd_valid <= 1'b0;
      xmit <= '0;
      xmit_valid <= 1'b0;
      apply_strobe <= 1'b0;
      apply_pending <= 1'b0;
    end
    else if (ce)
    begin
      cmd_valid <= rem_issue;
      xmit_valid <= expl_end;
      apply_strobe <= rem_issue && (ropt[OPT_APPLY] || rcmd == CMD_APPLY);
      if (rem_issue)
      begin
        cmd <= '{rcmd, param, plen_full[2:0], ropt[OPT_APPLY], ropt[OPT_NO_ACK],
          ropt[OPT_SECURE], is_query};
        if (ropt[OPT_APPLY] || rcmd == CMD_APPLY)
          apply_pending <= 1'b0;
        else if (!is_query)
          apply_pending <= 1'b1;
      end
      if (expl_end)
        xmit <= '{eff_opts, cluster, cluster == CLUSTER_LOOP};
    end
  end

  // =====================================================================
  // Response scheduling and byte emitter.
  rfc_tx_t tx_st; // Emitter state.
  rfc_kind_t tx_kind; // Frame being emitted.
  rfc_kind_t rsp_kind; // Frame waiting to be emitted.
  logic rsp_pend; // A response awaits the emitter.
  logic rsp_wait; // Waiting for the node to finish a command.
  logic loop_pend; // A loopback receive frame is owed.
  logic [7:0] rsp_status; // Status byte of the pending response.
  logic [31:0] val; // Returned setting, right aligned.
  logic [2:0] vlen; // Bytes of returned setting.
  logic fmt; // Receive format latched at loopback start.
  logic [15:0] idx; // Frame byte index.
  logic [7:0] tx_sum; // Running sum of emitted body bytes.
  logic [7:0] body; // Body byte at the current index.
  logic [7:0] mem_rd; // Payload byte from the store.

  wire [15:0] b_off = idx - FRAME_HDR;
  wire [15:0] dlen = len - POS_XDATA;
  wire [15:0] dbase = fmt ? RSP_RXE_LEN : RSP_RX_LEN;
  wire [15:0] blen = (tx_kind == K_REMOTE) ? RSP_REMOTE_LEN + {13'h0, vlen}
    : (tx_kind == K_STATUS) ? RSP_XSTAT_LEN : dbase + dlen;
  wire [15:0] last_idx = blen + FRAME_HDR;
  wire [1:0] vsh = 2'(PARAM_BYTES - vlen + 3'(b_off - RSP_REMOTE_LEN));
  wire [31:0] vshift = val << {vsh, 3'b000};
  wire busy = rsp_pend || rsp_wait || loop_pend || (tx_st != TX_IDLE);
  wire tx_start = (tx_st == TX_IDLE) && (rsp_pend || loop_pend);
  wire mem_wr = in_body && (ftype == TYPE_EXPLICIT) && (pos >= POS_XDATA)
    && ((pos - POS_XDATA) < 16'(DEPTH));

  rfc_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(mem_wr),
    .wr_addr(AW'(pos - POS_XDATA)),
    .wr_data(rx_byte),
    .rd_addr(AW'(b_off - dbase)),
    .rd_data(mem_rd)
  );

  // Body byte selection for the three response kinds.
  always_comb
  begin
    body = 8'h00;
    case (tx_kind)
      K_REMOTE:
        if (b_off == 16'h0000) body = TYPE_REMOTE_RSP;
        else if (b_off == 16'h0001) body = fid;
        else if (b_off < 16'h000A) body = pick64(dst64, b_off - 16'h0002);
        else if (b_off < 16'h000C) body = pick16(dst16, b_off);
        else if (b_off < 16'h000E) body = pick16(rcmd, b_off - 16'h000C);
        else if (b_off == 16'h000E) body = rsp_status;
        else body = vshift[31:24];
      K_STATUS:
        if (b_off == 16'h0000) body = TYPE_XSTAT;
        else if (b_off == 16'h0001) body = fid;
        else if (b_off < 16'h0004) body = pick16(dst16, b_off);
        else if (b_off == 16'h0005) body = rsp_status;
        else body = 8'h00;
      K_LOOP:
        if (b_off == 16'h0000) body = fmt ? TYPE_RX_EXPL : TYPE_RX;
        else if (b_off < 16'h0009) body = pick64(dst64, b_off - 16'h0001);
        else if (b_off < 16'h000B) body = pick16(dst16, b_off - 16'h0001);
        else if (b_off >= dbase) body = mem_rd;
        else if (b_off == dbase - 16'h0001) body = RX_OPT_ACKED;
        else if (b_off == 16'h000B) body = dep;
        else if (b_off == 16'h000C) body = sep;
        else if (b_off < 16'h000F) body = pick16(cluster, b_off - 16'h000D);
        else body = pick16(profile, b_off - 16'h000F);
      default:
        body = 8'h00;
    endcase
  end

  wire [7:0] frame_byte = (idx == 16'h0000) ? DELIM
    : (idx == 16'h0001) ? blen[15:8] : (idx == 16'h0002) ? blen[7:0]
    : (idx == last_idx) ? CSUM_BASE - tx_sum : body;

  // Scheduler: one response slot plus an owed loopback frame.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_pend <= 1'b0;
      rsp_wait <= 1'b0;
      loop_pend <= 1'b0;
      rsp_kind <= K_REMOTE;
      rsp_status <= ST_OK;
      val <= 32'h0;
      vlen <= 3'h0;
    end
    else if (ce)
    begin
      if (tx_start)
        rsp_pend <= 1'b0;
      if (rem_issue)
        rsp_wait <= (fid != 8'h00);
      if (rem_end && !rem_issue)
      begin
        // Local refusals answer at once, without involving the node.
        rsp_pend <= (fid != 8'h00);
        rsp_kind <= K_REMOTE;
        rsp_status <= secure_bad ? ST_ERR : ST_BAD_PARAM;
        vlen <= 3'h0;
      end
      if (rsp_wait && node_done)
      begin
        rsp_wait <= 1'b0;
        rsp_pend <= 1'b1;
        rsp_kind <= K_REMOTE;
        rsp_status <= node_err ? ST_ERR : ST_OK;
        val <= node_value;
        vlen <= (cmd.query && !node_err) ? node_len : 3'h0;
      end
      if (expl_end)
      begin
        rsp_pend <= (fid != 8'h00);
        rsp_kind <= K_STATUS;
        rsp_status <= deliver_fail ? DELIV_FAIL : ST_OK;
        loop_pend <= (cluster == CLUSTER_LOOP);
      end
      else if (tx_start && !rsp_pend)
        loop_pend <= 1'b0;
    end
  end

  // Emitter: fetch a byte, present it, hold it until the host takes it.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_st <= TX_IDLE;
      tx_kind <= K_REMOTE;
      idx <= 16'h0000;
      tx_sum <= 8'h00;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      fmt <= 1'b0;
      rx_ready <= 1'b1;
    end
    else if (ce)
    begin
      // The parser is held off while a response is owed, so captured fields stay stable.
      rx_ready <= !(busy || good_end);
      case (tx_st)
        TX_IDLE:
          if (tx_start)
          begin
            tx_kind <= rsp_pend ? rsp_kind : K_LOOP;
            fmt <= ctrl[CTRL_FMT];
            idx <= 16'h0000;
            tx_sum <= 8'h00;
            tx_st <= TX_FETCH;
          end
        TX_FETCH:
          tx_st <= TX_PUT;
        TX_PUT:
        begin
          tx_byte <= frame_byte;
          tx_valid <= 1'b1;
          if (idx >= FRAME_HDR && idx != last_idx)
            tx_sum <= tx_sum + frame_byte;
          tx_st <= TX_WAIT;
        end
        TX_WAIT:
          if (tx_ready)
          begin
            tx_valid <= 1'b0;
            idx <= idx + 16'h0001;
            tx_st <= (idx == last_idx) ? TX_IDLE : TX_FETCH;
          end
        default:
          tx_st <= TX_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Assertions.
  sequence s_first_put;
    tx_st == TX_PUT && idx == 16'h0000;
  endsequence
  sequence s_status_start;
    tx_start && rsp_kind == K_STATUS;
  endsequence

  a_delim_start: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_first_put |=> tx_byte == DELIM && tx_valid)
    else $error("response frame does not open with the delimiter");
  a_len_field: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    frame_end |-> pos == len)
    else $error("checksum byte taken at wrong body position");
  a_zero_id_quiet: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (tx_start && rsp_pend) |-> fid != 8'h00)
    else $error("response started for a zero identifier");
  a_remote_type: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (tx_st == TX_PUT && tx_kind == K_REMOTE && idx == FRAME_HDR)
      |=> tx_byte == TYPE_REMOTE_RSP)
    else $error("remote response type is wrong");
  a_apply_pend: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (rem_issue && !ropt[OPT_APPLY] && rcmd != CMD_APPLY && !is_query)
      |=> apply_pending && !apply_strobe)
    else $error("queued change not held pending");
  a_default_opts: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    xmit_valid && $past(xopt) == 8'h00 |-> xmit.opts == $past(ctrl[7:0]))
    else $error("default transmit options not used");
  a_status_follow: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (expl_end && fid != 8'h00 && !busy) |=> ##[0:2] s_status_start)
    else $error("transmit status not scheduled");
  a_bad_drop: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (frame_end && !csum_good) |=> !cmd_valid && !xmit_valid ##1 !rsp_pend)
    else $error("bad checksum frame was acted on");
  a_loop_type: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (tx_st == TX_PUT && tx_kind == K_LOOP && idx == FRAME_HDR)
      |=> tx_byte == (fmt ? TYPE_RX_EXPL : TYPE_RX))
    else $error("loopback receive type does not follow format");
endmodule

// file: test/rfc_host_model.sv
// Host model: offers frame bytes and takes emitted bytes with stalls.
`timescale 1ns/1ps
module rfc_host_model (
  input wire logic clk,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$]; // Bytes taken from the codec.
  logic slow = 1'b0; // Stalls every other cycle.
  initial
  begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // ====================
  // Each byte is held until taken; ready is read mid-cycle to avoid an edge race.
  task automatic send(input logic [7:0] b[$]);
    @(posedge clk);
    foreach (b[i])
    begin
      rx_byte <= b[i];
      rx_valid <= 1'b1;
      do @(negedge clk); while (!rx_ready);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_byte <= ~b[b.size()-1];
  endtask
  // Slow reader, so the codec must hold every byte.
  always @(posedge clk)
  begin
    slow <= ~slow;
    tx_ready <= slow;
    if (tx_valid && tx_ready)
      got.push_back(tx_byte);
  end
endmodule

// file: test/rfc_codec_tb_top.sv
// Self-checking bench of the remote command frame codec.
`timescale 1ns/1ps
module rfc_codec_tb_top
  import rfc_pkg::*;
;
  typedef logic [7:0] rfc_tbq_t[$];
  logic clk, sys_rst, ce, rx_valid, rx_ready, tx_valid, tx_ready, reg_wr, reg_rd, apl;
  logic cmd_valid, apply_strobe, node_done, node_err, xmit_valid, deliver_fail;
  logic [7:0] rx_byte, tx_byte;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, node_value;
  logic [2:0] node_len;
  rfc_cmd_t cmd, cmd_q;
  rfc_xmit_t xmit, xm_q;
  rfc_tbq_t dq;
  int err_total = 0, check_count = 0, n_ev = 0, cyc = 0;
  rfc_codec i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd(cmd), .cmd_valid(cmd_valid),
    .apply_strobe(apply_strobe), .node_done(node_done), .node_err(node_err),
    .node_value(node_value), .node_len(node_len), .xmit(xmit), .xmit_valid(xmit_valid),
    .deliver_fail(deliver_fail));
  rfc_host_model host (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ====================
  // Latch every command or transmit pulse and count them.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cmd_valid)
    begin
      cmd_q <= cmd;
      apl <= apply_strobe;
    end
    if (xmit_valid)
      xm_q <= xmit;
    if (cmd_valid || xmit_valid)
      n_ev <= n_ev + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wraps a body with start, length and checksum; flip spoils the checksum.
  function automatic rfc_tbq_t full(input rfc_tbq_t b, input logic [7:0] flip);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    return {DELIM, 8'h00, 8'(b.size()), b, (8'hFF - s) ^ flip};
  endfunction
  function automatic rfc_tbq_t hdr(input logic [7:0] t, input logic [7:0] id);
    return '{t, id, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'hFF, 8'hFE};
  endfunction
  task automatic wait_ev(input int c);
    for (int k = 0; k < 400 && n_ev == c; k++) @(negedge clk);
  endtask
  task automatic expect_rsp(input rfc_tbq_t b);
    rfc_tbq_t e;
    e = full(b, 8'h00);
    for (int k = 0; k < 900 && host.got.size() < e.size(); k++) @(negedge clk);
    foreach (e[i]) chk(host.got[i], e[i]);
    repeat (e.size()) void'(host.got.pop_front());
  endtask
  task automatic reg_op(input logic [3:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    if (!wr)
      chk(reg_rdata, d);
  endtask
  // ====================
  // Query with an ID, then a bad checksum, then a set with ID zero.
  task automatic s_remote;
    int c;
    c = n_ev;
    host.send(full({hdr(8'h17, 8'hFA), 8'h00, 8'h54, 8'h50}, 8'h00));
    wait_ev(c);
    chk(cmd_q.command, 32'h5450);
    chk(cmd_q.query, 32'h1);
    @(posedge clk);
    node_done <= 1'b1;
    node_value <= 32'h1234;
    node_len <= 3'h2;
    @(posedge clk);
    node_done <= 1'b0;
    expect_rsp({hdr(8'h97, 8'hFA), 8'h54, 8'h50, 8'h00, 8'h12, 8'h34});
    c = n_ev;
    host.send(full({hdr(8'h17, 8'hFA), 8'h00, 8'h54, 8'h50}, 8'h01));
    repeat (150) @(posedge clk);
    chk(n_ev, c);
    host.send(full({hdr(8'h17, 8'h00), 8'h03, 8'h4E, 8'h49, 8'h41}, 8'h00));
    wait_ev(c);
    chk({apl, cmd_q.apply, cmd_q.plen}, 32'h19);
    chk(cmd_q.no_ack, 32'h1);
    chk(cmd_q.param, 32'h41);
    repeat (150) @(posedge clk);
    chk(host.got.size(), 0);
    // Local refusals: secure bit without a session, then an oversized parameter.
    c = n_ev;
    host.send(full({hdr(8'h17, 8'h31), 8'h10, 8'h54, 8'h50}, 8'h00));
    expect_rsp({hdr(8'h97, 8'h31), 8'h54, 8'h50, 8'h01});
    host.send(full({hdr(8'h17, 8'h32), 8'h00, 8'h4E, 8'h49, 8'h01, 8'h02, 8'h03, 8'h04,
      8'h05}, 8'h00));
    expect_rsp({hdr(8'h97, 8'h32), 8'h4E, 8'h49, 8'h03});
    chk(n_ev, c);
  endtask
  // Explicit send with zero options, then a loopback send.
  task automatic s_explicit;
    int c;
    reg_op(REG_CTRL, 1'b1, 32'hC3);
    reg_op(REG_CTRL, 1'b0, 32'hC3);
    reg_op(4'h8, 1'b0, 32'h0);
    reg_op(REG_STAT, 1'b0, 32'h00010400);
    deliver_fail <= 1'b1;
    dq = '{8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
    c = n_ev;
    host.send(full({hdr(8'h11, 8'h87), 8'hE8, 8'hE8, 8'h00, 8'h11, 8'hC1, 8'h05,
      8'h00, 8'h00, dq}, 8'h00));
    wait_ev(c);
    chk(xm_q.opts, 32'hC3);
    expect_rsp('{8'h8B, 8'h87, 8'hFF, 8'hFE, 8'h00, 8'h21, 8'h00});
    deliver_fail <= 1'b0;
    c = n_ev;
    host.send(full({hdr(8'h11, 8'hF8), 8'hE8, 8'hE8, 8'h00, 8'h12, 8'hC1, 8'h05,
      8'h00, 8'h01, dq}, 8'h00));
    wait_ev(c);
    chk({xm_q.opts, xm_q.loopback}, 32'h3);
    expect_rsp('{8'h8B, 8'hF8, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h00});
    expect_rsp({8'h90, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'hFF, 8'hFE,
      8'h01, dq});
    // Explicit receive format, and no status frame for a zero identifier.
    reg_op(REG_CTRL, 1'b1, 32'h100);
    host.send(full({hdr(8'h11, 8'h00), 8'hE8, 8'hE8, 8'h00, 8'h12, 8'hC1, 8'h05,
      8'h00, 8'h01, dq}, 8'h00));
    expect_rsp({8'h91, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'hFF, 8'hFE,
      8'hE8, 8'hE8, 8'h00, 8'h12, 8'hC1, 8'h05, 8'h01, dq});
  endtask
  task automatic close_out;
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {sys_rst, ce, reg_wr, reg_rd, node_done, node_err, deliver_fail} = 7'h60;
    {reg_addr, reg_wdata, node_value, node_len} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    s_remote();
    s_explicit();
    close_out();
  end
endmodule
